/* File: pin_map_pkg.sv */
package pin_map_pkg;

  localparam int unsigned PIN_COUNT   = 8;
  localparam int unsigned CODE_W      = 6;
  localparam int unsigned AD_W        = 10;
  localparam int unsigned STATUS_W    = 32;
  localparam int unsigned CTRL_W      = 16;

  // mapping register window on the control port
  localparam logic [9:0] PIN0_MAP_ADDR = 10'h00f;
  localparam logic [9:0] PIN7_MAP_ADDR = 10'h016;

  // function code layout
  localparam int unsigned DIR_BIT     = 5;
  localparam int unsigned SEL_MSB     = 4;
  localparam int unsigned CTRL_IDX_MSB = 3;

  // output function codes
  localparam logic [5:0] FN_FIELD_FLAG_ERR   = 6'h01;
  localparam logic [5:0] FN_ACTIVE_FLAG_ERR  = 6'h02;
  localparam logic [5:0] FN_ANCIL_FLAG_ERR   = 6'h03;
  localparam logic [5:0] FN_CRC_ERR          = 6'h04;
  localparam logic [5:0] FN_ANC_FIFO_90      = 6'h07;
  localparam logic [5:0] FN_SHORT_MESSAGE    = 6'h08;
  localparam logic [5:0] FN_FULL_MESSAGE     = 6'h09;
  localparam logic [5:0] FN_SAV              = 6'h0d;
  localparam logic [5:0] FN_EAV              = 6'h0e;
  localparam logic [5:0] FN_NEW_SYNC         = 6'h0f;
  localparam logic [5:0] FN_CRC_LUMA         = 6'h10;
  localparam logic [5:0] FN_CRC_CHROMA       = 6'h11;
  localparam logic [5:0] FN_FIELD            = 6'h12;
  localparam logic [5:0] FN_VERT             = 6'h13;
  localparam logic [5:0] FN_HORZ             = 6'h14;
  localparam logic [5:0] FN_FORMAT0          = 6'h15;
  localparam logic [5:0] FN_FORMAT4          = 6'h19;
  localparam logic [5:0] FN_VFIFO_FULL       = 6'h1a;
  localparam logic [5:0] FN_VFIFO_EMPTY      = 6'h1b;
  localparam logic [5:0] FN_LOCK_DETECT      = 6'h1c;
  localparam logic [5:0] FN_SELF_TEST        = 6'h1d;
  localparam logic [5:0] FN_FIFO_OVERRUN     = 6'h1e;
  localparam logic [5:0] FN_ANCIL_SUM_ERR    = 6'h1f;
  // input function codes
  localparam logic [5:0] FN_EDH_FORCE        = 6'h20;
  localparam logic [5:0] FN_PATTERN_SEL0     = 6'h21;
  localparam logic [5:0] FN_EDH_ENABLE       = 6'h27;
  localparam logic [5:0] FN_TEST_GEN_ENABLE  = 6'h28;
  localparam logic [5:0] FN_PATTERN_FILTER   = 6'h2c;
  localparam logic [5:0] FN_DE_DITHER        = 6'h2d;
  localparam logic [5:0] FN_FRAMING_ENABLE   = 6'h2e;
  localparam logic [5:0] FN_FIFO_EXTRACT     = 6'h2f;

  // power-on mapping, pin 7 first
  localparam logic [7:0][5:0] MAP_RESET = {
    FN_EAV, FN_VFIFO_EMPTY, FN_CRC_ERR, FN_LOCK_DETECT,
    FN_FORMAT4, FN_HORZ, FN_VERT, FN_FIELD
  };

endpackage : pin_map_pkg

/* File: pin_map_if.sv */
`timescale 1ns/1ns
interface pin_map_if;
  logic [7:0][5:0] map;
  logic [7:0]      pins_in;
  logic [31:0]     status;
  logic [15:0]     ctrl_stored;
  logic [7:0]      pins_out;
  logic [7:0]      pins_oe;
  logic [15:0]     ctrl_out;

  modport owner
  (
    output map,
    output pins_in,
    output status,
    output ctrl_stored,
    input  pins_out,
    input  pins_oe,
    input  ctrl_out
  );

  modport router
  (
    input  map,
    input  pins_in,
    input  status,
    input  ctrl_stored,
    output pins_out,
    output pins_oe,
    output ctrl_out
  );
endinterface : pin_map_if

/* File: pin_router.sv */
`timescale 1ns/1ns
module pin_router
(
  input  wire logic     ref_clk,
  input  wire logic     rst_n,
  pin_map_if.router     bus
);

  typedef struct packed {
    logic [7:0]  pins_out;
    logic [7:0]  pins_oe;
    logic [15:0] ctrl_out;
  } router_s;

  router_s state_reg;
  router_s state_next;

  always_comb
  begin
    state_next          = '0;
    state_next.ctrl_out = bus.ctrl_stored;
    // ascending loop: with two pins on one control bit, the higher pin wins
    for (int p = 0; p < 8; p++)
    begin
      if (!bus.map[p][pin_map_pkg::DIR_BIT]) // R2
      begin
        state_next.pins_oe[p]  = 1'b1;
        state_next.pins_out[p] = bus.status[bus.map[p][pin_map_pkg::SEL_MSB:0]]; // R3 R13
      end
      else if (!bus.map[p][pin_map_pkg::SEL_MSB])
      begin
        // codes 30..3f name no control bit; such a pin is only released
        state_next.ctrl_out[bus.map[p][pin_map_pkg::CTRL_IDX_MSB:0]] = bus.pins_in[p]; // R10 R13
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign bus.pins_out = state_reg.pins_out;
  assign bus.pins_oe  = state_reg.pins_oe;
  assign bus.ctrl_out = state_reg.ctrl_out;

endmodule : pin_router

/* File: multifunction_port_pin_mapper.sv */
`timescale 1ns/1ns
// Operation
// R1 - eight mapping registers at 0F..16h, pin 0 lowest
// R2 - code bit 5 high makes the pin an input, low an output
// R3 - code bits 4:0 choose the register bit tied to the pin
// R4 - host must match direction to the function's own nature
// R5 - host writes: select low, write low, address, clock edge
// R6 - host then presents data word and gives a second clock edge
// R7 - output codes 01-04 and 07-09 pick flag, CRC and message status
// R8 - codes 0D-19 pick sync, CRC, timing and format bits
// R9 - codes 1A-1F pick FIFO, lock, self-test, overrun, checksum status
// R10 - codes 20-2F drive EDH, pattern, generator, filter, dither, framing, extract
// R11 - host must not use reserved codes 00,05,06,0A-0C,29-2B
// R12 - power-on mapping F,V,H,format4,lock,CRC,empty,EAV, all outputs
// R13 - outputs follow selected bit; inputs override the selected control bit
module multifunction_port_pin_mapper
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        port_clk,
  input  wire logic        port_function_select,
  input  wire logic        port_read_select,
  input  wire logic [9:0]  ad_in,
  output logic      [9:0]  ad_out,
  output logic             ad_oe,
  input  wire logic [7:0]  io_in,
  output logic      [7:0]  io_out,
  output logic      [7:0]  io_oe,
  input  wire logic [31:0] status_bits,
  input  wire logic [15:0] ctrl_stored,
  output logic      [15:0] ctrl_out
);

  typedef enum logic [0:0] {
    PH_ADDR,
    PH_DATA
  } phase_e;

  typedef struct packed {
    logic [2:0]       clk_sync;
    logic [1:0]       sel_sync;
    logic [1:0]       rd_sync;
    logic [1:0][9:0]  ad_sync;
    logic [1:0][7:0]  io_sync;
    phase_e           phase;
    logic             addr_hit;
    logic [2:0]       addr_idx;
    logic             read_op;
    logic [7:0][5:0]  map;
    logic [9:0]       ad_out;
    logic             ad_oe;
  } top_s;

  top_s       state_reg;
  top_s       state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       clk_rise;
  logic       ctrl_access;
  logic       hit;
  logic [9:0] offset;

  pin_map_if bus ();

  // reset is released on the clock so no flop leaves reset on a partial edge
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  function automatic logic map_addr_hit(input logic [9:0] addr);
    map_addr_hit = (addr >= pin_map_pkg::PIN0_MAP_ADDR) &&
                   (addr <= pin_map_pkg::PIN7_MAP_ADDR);
  endfunction : map_addr_hit

  assign clk_rise    = state_reg.clk_sync[1] & ~state_reg.clk_sync[2];
  assign ctrl_access = ~state_reg.sel_sync[1];
  assign offset      = state_reg.ad_sync[1] - pin_map_pkg::PIN0_MAP_ADDR;
  assign hit         = map_addr_hit(state_reg.ad_sync[1]);

  always_comb
  begin
    state_next = state_reg;
    // every port pin crosses two flops before anything looks at it
    state_next.clk_sync = {state_reg.clk_sync[1:0], port_clk};
    state_next.sel_sync = {state_reg.sel_sync[0], port_function_select};
    state_next.rd_sync  = {state_reg.rd_sync[0], port_read_select};
    state_next.ad_sync  = {state_reg.ad_sync[0], ad_in};
    state_next.io_sync  = {state_reg.io_sync[0], io_in};

    if (!ctrl_access)
    begin
      // leaving control mode aborts a half-done access and frees the bus
      state_next.phase = PH_ADDR;
      state_next.ad_oe = 1'b0;
    end
    else if (clk_rise)
    begin
      unique case (state_reg.phase)
        PH_ADDR:
        begin
          state_next.addr_hit = hit; // R1
          state_next.addr_idx = offset[2:0]; // R1
          state_next.read_op  = state_reg.rd_sync[1];
          state_next.phase    = PH_DATA;
          if (state_reg.rd_sync[1])
          begin
            state_next.ad_oe  = 1'b1;
            state_next.ad_out = hit ? {4'h0, state_reg.map[offset[2:0]]} : 10'h000;
          end
        end
        PH_DATA:
        begin
          state_next.phase = PH_ADDR;
          state_next.ad_oe = 1'b0;
          if (!state_reg.read_op && state_reg.addr_hit)
          begin
            // only the six code bits are kept; the upper data bits are ignored
            state_next.map[state_reg.addr_idx] = state_reg.ad_sync[1][5:0]; // R1 R2 R3
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg          <= '0;
      // select idles high; a zero here would look like a control access after reset
      state_reg.sel_sync <= 2'h3;
      state_reg.phase    <= PH_ADDR;
      state_reg.map   <= pin_map_pkg::MAP_RESET; // R12
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign bus.map         = state_reg.map;
  assign bus.pins_in     = state_reg.io_sync[1];
  assign bus.status      = status_bits; // R7 R8 R9
  assign bus.ctrl_stored = ctrl_stored;

  pin_router u_router
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bus     (bus.router)
  );

  assign ad_out   = state_reg.ad_out;
  assign ad_oe    = state_reg.ad_oe;
  assign io_out   = bus.pins_out;
  assign io_oe    = bus.pins_oe;
  assign ctrl_out = bus.ctrl_out;

endmodule : multifunction_port_pin_mapper

/* File: pin_map_props.sv */
`timescale 1ns/1ns
module pin_map_props
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        port_clk,
  input wire logic        port_function_select,
  input wire logic        port_read_select,
  input wire logic [9:0]  ad_out,
  input wire logic        ad_oe,
  input wire logic [7:0]  io_out,
  input wire logic [7:0]  io_oe,
  input wire logic [31:0] status_bits,
  input wire logic [15:0] ctrl_stored,
  input wire logic [15:0] ctrl_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_out_low: assert property ($past(status_bits) == '0 && $past(status_bits, 2) == '0
    |-> (io_out & io_oe) == '0) else $error("pin high with status low");
  chk_out_high: assert property ($past(status_bits) == '1 && $past(status_bits, 2) == '1
    |-> (io_out & io_oe) == io_oe) else $error("pin low with status high");
  chk_ctrl_pass: assert property ($past(io_oe, 2) == '1 && $past(io_oe) == '1 && io_oe == '1
    |-> ctrl_out == $past(ctrl_stored)) else $error("control overridden by output pin");
  chk_code_width: assert property (ad_oe |-> ad_out[9:6] == 4'h0)
    else $error("read data beyond code width");
  chk_read_cause: assert property ($rose(ad_oe) |-> $past(port_read_select, 3)
    && !$past(port_function_select, 3)) else $error("bus driven without read");
  chk_read_ends: assert property ($rose(port_clk) && ad_oe |-> ##[1:6] !ad_oe)
    else $error("bus held past data strobe");
  chk_read_holds: assert property ((!port_clk && !port_function_select) [*6] ##0 ad_oe
    |=> ad_oe) else $error("read data dropped early");
  chk_deselect: assert property (port_function_select [*6] |-> !ad_oe)
    else $error("bus driven while deselected");
  cover property ($rose(ad_oe));
  cover property (io_oe != 8'hff);
  cover property (ctrl_out != ctrl_stored);
endmodule : pin_map_props
bind multifunction_port_pin_mapper pin_map_props pin_map_props_inst (.ref_clk, .resetn,
  .port_clk, .port_function_select, .port_read_select, .ad_out, .ad_oe, .io_out, .io_oe,
  .status_bits, .ctrl_stored, .ctrl_out);

/* File: host_port_model.sv */
`timescale 1ns/1ns
module host_port_model
(
  input  wire logic       ref_clk,
  output logic            port_clk,
  output logic            port_function_select,
  output logic            port_read_select,
  output logic      [9:0] ad_in,
  input  wire logic [9:0] ad_out,
  input  wire logic       ad_oe
);
  logic [9:0] drv = '0;
  logic       drv_en = 1'b0;
  initial
  begin
    port_clk = 1'b0;
    port_function_select = 1'b1;
    port_read_select = 1'b0;
  end
  // released bus settles to the pull-down level
  assign ad_in = ad_oe ? ad_out : (drv_en ? drv : 10'h000);
  task automatic strobe(input int h);
    repeat (h) @(negedge ref_clk);
    port_clk = 1'b1;
    repeat (h) @(negedge ref_clk);
    port_clk = 1'b0;
  endtask : strobe
  task automatic xfer(input logic rd, input logic [9:0] a, input logic [9:0] d, input int h,
                      output logic [9:0] q);
    port_function_select = 1'b0;
    port_read_select = rd;
    drv = a;
    drv_en = 1'b1;
    strobe(h);
    drv_en = !rd;
    drv = d;
    repeat (2) @(negedge ref_clk);
    q = ad_oe ? ad_out : 10'h3ff;
    strobe(h);
    drv_en = 1'b0;
    port_function_select = 1'b1;
    repeat (h) @(negedge ref_clk);
  endtask : xfer
endmodule : host_port_model

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
  logic            ref_clk, resetn, port_clk, port_function_select, port_read_select, ad_oe;
  logic [9:0]      ad_in, ad_out, q;
  logic [7:0]      io_in, io_out, io_oe;
  logic [31:0]     status_bits;
  logic [15:0]     ctrl_stored, ctrl_out;
  logic [7:0][5:0] m;
  int              seed = 11, fails = 0, total_checks = 0, p;
  multifunction_port_pin_mapper multifunction_port_pin_mapper_inst (.ref_clk, .resetn,
    .port_clk, .port_function_select, .port_read_select, .ad_in, .ad_out, .ad_oe, .io_in,
    .io_out, .io_oe, .status_bits, .ctrl_stored, .ctrl_out);
  host_port_model host_port_model_inst (.ref_clk, .port_clk, .port_function_select,
    .port_read_select, .ad_in, .ad_out, .ad_oe);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] exp_io(input logic [7:0][5:0] mm, input logic [31:0] st);
    for (int i = 0; i < 8; i++)
      exp_io[i] = !mm[i][5] && st[mm[i][4:0]];
  endfunction : exp_io
  function automatic logic [15:0] exp_ctrl(input logic [7:0][5:0] mm, input logic [15:0] c,
                                           input logic [7:0] pi);
    exp_ctrl = c;
    for (int i = 0; i < 8; i++)
      if (mm[i][5:4] == 2'b10)
        exp_ctrl[mm[i][3:0]] = pi[i];
  endfunction : exp_ctrl
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic pins;
    logic [7:0] e;
    status_bits = $random(seed);
    ctrl_stored = 16'($random(seed));
    io_in = 8'($random(seed));
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
      e[i] = !m[i][5];
    check("oe", 16'(io_oe), 16'(e));
    check("out", 16'(io_out & e), 16'(exp_io(m, status_bits)));
    check("ctrl", ctrl_out, exp_ctrl(m, ctrl_stored, io_in));
  endtask : pins
  task automatic rd_all;
    for (int i = 0; i < 8; i++)
    begin
      host_port_model_inst.xfer(1'b1, 10'h00f + 10'(i), '0, 4 + 5 * (i % 2), q);
      check("map", 16'(q), {10'h000, m[i]});
    end
    pins();
  endtask : rd_all
  initial
  begin
    #100us;
    fails++;
    tally_and_finish();
  end
  initial
  begin
    resetn = 1'b0;
    status_bits = '0;
    ctrl_stored = '0;
    io_in = '0;
    m = pin_map_pkg::MAP_RESET;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (8) @(negedge ref_clk);
    status_bits = '1;
    repeat (4) @(negedge ref_clk);
    check("po", {io_oe, io_out}, 16'hffff);
    rd_all();
    $display("power-on map done");
    for (int c = 1; c < 48; c++)
      if (!(c inside {5, 6, [10:12], [41:43]}))
      begin
        p = {$random(seed)} % 8;
        host_port_model_inst.xfer(1'b0, 10'h00f + 10'(p), {4'($random(seed)), 6'(c)}, 4, q);
        m[p] = 6'(c);
        pins();
      end
    $display("code sweep done");
    host_port_model_inst.xfer(1'b0, 10'h017, 10'h000, 4, q);
    host_port_model_inst.xfer(1'b0, 10'h00e, 10'h000, 4, q);
    host_port_model_inst.xfer(1'b1, 10'h017, '0, 4, q);
    check("nomap", 16'(q), 16'h0000);
    // a code above the input functions leaves the pin released and overrides nothing
    host_port_model_inst.xfer(1'b0, 10'h011, 10'h03a, 4, q);
    m[2] = 6'h3a;
    pins();
    rd_all();
    $display("unmapped access done");
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    m = pin_map_pkg::MAP_RESET;
    repeat (8) @(negedge ref_clk);
    rd_all();
    $display("second reset done");
    tally_and_finish();
  end
endmodule : tb
